/* verif/gpp_port_sva.sv */
// Bus and pin-enable checks for the GPIO port, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module gpp_port_sva
   import gpp_pkg::*;
(
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic [GPP_ADDR_W-1:0] s_axi_araddr,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic [1:0]            s_axi_rresp,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic [GPP_PINS-1:0]   gpio_oe
);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // The reset check must run while reset is held, so it is never disabled.
   chk_oe_reset:
      assert property (disable iff (1'b0) !aresetn ##1 !aresetn |-> gpio_oe == 5'h00)
      else $error("pin driven during reset");
   chk_oe_change:
      assert property ($changed(gpio_oe) |-> $past(s_axi_bvalid))
      else $error("pin enable changed without a write");
   chk_w_resp:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response late or early");
   chk_aw_block:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   chk_b_done:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write response not retired");
   chk_r_resp:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data not returned next cycle");
   chk_r_done:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read response not retired");
   chk_r_slverr:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h24
                       |=> s_axi_rresp == GPP_RESP_SLVERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");
endmodule
bind gpp_gpio_pwm_port gpp_port_sva u_sva (.*);
`default_nettype wire

/* verif/gpp_pwm_partner.sv */
// External pin partner: loops driven pins back and sources static or PWM levels.
`timescale 1ns/1ps
`default_nettype none
module gpp_pwm_partner
   import gpp_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic [GPP_PINS-1:0] gpio_out,
   input  wire logic [GPP_PINS-1:0] gpio_oe,
   input  wire logic [GPP_PINS-1:0] pwm_en,
   input  wire logic [GPP_PINS-1:0] static_lvl,
   input  wire logic [15:0]         lo_cyc,
   input  wire logic [15:0]         hi_cyc,
   output wire logic [GPP_PINS-1:0] gpio_in
);
   logic [15:0] pos_r = 16'h0000;
   logic        wave;

   // A shortened period wraps at once, so the decoder sees a clean restart.
   always_ff @(posedge aclk) begin
      if (pos_r + 16'h0001 >= lo_cyc + hi_cyc)
         pos_r <= 16'h0000;
      else
         pos_r <= pos_r + 16'h0001;
   end

   assign wave = (pos_r >= lo_cyc);
   assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ((pwm_en & {GPP_PINS{wave}}) | (~pwm_en & static_lvl)));
endmodule
`default_nettype wire

/* verif/gpp_tb.sv */
// Self-checking testbench for the GPIO port: bus tasks and directed scenarios.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
   num_checks++; \
   if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); \
   end \
end
module testbench
   import gpp_pkg::*;
;
   logic                  aclk;
   logic                  aresetn;
   logic [GPP_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]            s_axi_wstrb;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic                  s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]            s_axi_bresp, s_axi_rresp, rs;
   logic [GPP_PINS-1:0]   gpio_in, gpio_out, gpio_oe, pwm_en, static_lvl;
   logic                  fault_summary_in, measurement_indicator_out, overcurrent_out_a, overcurrent_out_b;
   logic [15:0]           lo_cyc, hi_cyc;
   int                    n_mismatch, num_checks, cyc, t1, t2, t3, t4, t5;

   gpp_gpio_pwm_port dut (.*);
   gpp_pwm_partner   u_partner (.*);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   always @(posedge aclk) cyc <= cyc + 1;

   // ----------------------------------------------------------------
   // Bus tasks and closing
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic got;
      int   n;
      got = 1'b0;
      n   = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            got = 1'b1;
            `CHK(s_axi_bresp, er)
         end
      end
      s_axi_bready <= 1'b0;
      // Both halves are taken at the first edge, so the answer is seen at the third.
      `CHK(n, 3)
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic got;
      int   n;
      got = 1'b0;
      n   = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            got = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
      end
      s_axi_rready <= 1'b0;
      // The address is taken at the first edge and the data seen at the second.
      `CHK(n, 2)
   endtask

   task automatic wedge(input logic v, output int t);
      do @(posedge aclk); while (gpio_out[2] !== v);
      t = cyc;
   endtask

   task summarize;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // The full sequence needs about 25k cycles; more than twice that means a hang.
   initial begin
      repeat (60000) @(posedge aclk);
      n_mismatch++;
      summarize;
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, pwm_en, cyc} = '0;
      {fault_summary_in, measurement_indicator_out, overcurrent_out_a, overcurrent_out_b} = 4'h6;
      s_axi_wstrb = 4'hF;
      static_lvl  = 5'h15;
      lo_cyc      = 16'h0380;
      hi_cyc      = 16'h0080;
      aresetn     = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK(gpio_oe, 5'h00)
      for (int i = 0; i < 9; i++) begin
         if (i != 3) begin
            axi_rd(8'(i * 4), rd, rs);
            `CHK(rd, GPP_RST_WORD)
         end
      end
      axi_rd(GPP_ADDR_RDBK, rd, rs);
      `CHK(rd, 32'h00000111)
      axi_wr(8'h24, 32'hFFFFFFFF, GPP_RESP_SLVERR);
      axi_rd(8'h24, rd, rs);
      `CHK(rs, GPP_RESP_SLVERR)
      axi_wr(GPP_ADDR_CTRL, 32'h000A001F, GPP_RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK(gpio_oe, 5'h1F)
      `CHK(gpio_out, 5'h0A)
      repeat (8) @(posedge aclk);
      axi_rd(GPP_ADDR_RDBK, rd, rs);
      `CHK(rd, 32'h00000044)
      axi_wr(GPP_ADDR_SRC, 32'h0000468F, GPP_RESP_OKAY);
      axi_rd(GPP_ADDR_SRC, rd, rs);
      `CHK(rd, 32'h00004688)
      repeat (3) @(posedge aclk);
      `CHK(gpio_out, 5'h0C)
      axi_wr(GPP_ADDR_CTRL, 32'h001F001F, GPP_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(gpio_out, 5'h0D)
      {fault_summary_in, measurement_indicator_out, overcurrent_out_a, overcurrent_out_b} <= 4'h9;
      repeat (3) @(posedge aclk);
      `CHK(gpio_out, 5'h13)
      axi_wr(GPP_ADDR_SRC, 32'h00000000, GPP_RESP_OKAY);
      axi_wr(GPP_ADDR_TB, 32'h00000030, GPP_RESP_OKAY);
      axi_wr(8'h18, 32'h03010103, GPP_RESP_OKAY);
      axi_wr(GPP_ADDR_CTRL, 32'h00000404, GPP_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK(gpio_out[2], 1'b0)
      wedge(1'b1, t5);
      wedge(1'b0, t1);
      `CHK(t1 - t5, 1 * 1024)
      axi_wr(GPP_ADDR_CTRL, 32'h00040404, GPP_RESP_OKAY);
      wedge(1'b1, t2);
      wedge(1'b0, t3);
      wedge(1'b1, t4);
      wedge(1'b0, t5);
      `CHK(t2 - t1, 3 * 1024)
      `CHK(t3 - t2, 1 * 1024)
      `CHK(t4 - t3, 1 * 1024)
      `CHK(t5 - t4, 3 * 1024)
      axi_wr(GPP_ADDR_CTRL, 32'h00000800, GPP_RESP_OKAY);
      axi_wr(GPP_ADDR_TB, 32'h00000000, GPP_RESP_OKAY);
      pwm_en <= 5'h08;
      for (int i = 0; i < 4; i++) begin
         lo_cyc <= 16'((7 - 2 * i) * 128);
         hi_cyc <= 16'((1 + 2 * i) * 128);
         repeat (3200) @(posedge aclk);
         axi_rd(GPP_ADDR_RDBK, rd, rs);
         `CHK(rd[7:6], 2'(i))
      end
      axi_wr(GPP_ADDR_CTRL, 32'h0000001F, GPP_RESP_OKAY);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      `CHK(gpio_oe, 5'h00)
      aresetn <= 1'b1;
      summarize;
   end
endmodule
`default_nettype wire

/* verilog/gpp_gpio_pwm_port.sv */
// Five-pin GPIO port with static and PWM coding, reached over AXI4-Lite.
//
// Behaviour
// RQ1: Direction bit selects input or output per pin.
// RQ2: Format bit selects static or PWM coding.
// RQ3: Four pins may output fault, indicator, overcurrent.
// RQ4: Host sets output direction with special source.
// RQ5: Static output drives data bit push-pull.
// RQ6: Special source ignores the output data bit.
// RQ7: Pin level always sampled into two-bit readback.
// RQ8: All pins are inputs during reset.
// RQ9: Data bit chooses low or high counter pair.
// RQ10: Phase times are counts times time base.
// RQ11: Every PWM period starts with low phase.
// RQ12: New settings apply at next period start.
// RQ13: Time base setting 3h is 1024 clocks.
// RQ14: PWM input decoded into four readback levels.
// RQ15: Readback settles within two PWM cycles.
// RQ16: Settings 0h-2h give shorter power-of-two bases.
// RQ17: Duty quarters map onto the four codes.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gpp_gpio_pwm_port
   import gpp_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [GPP_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output var  logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output var  logic                  s_axi_wready,
   output var  logic [1:0]            s_axi_bresp,
   output var  logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [GPP_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output var  logic                  s_axi_arready,
   output var  logic [31:0]           s_axi_rdata,
   output var  logic [1:0]            s_axi_rresp,
   output var  logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic [GPP_PINS-1:0]   gpio_in,
   output var  logic [GPP_PINS-1:0]   gpio_out,
   output var  logic [GPP_PINS-1:0]   gpio_oe,
   input  wire logic                  fault_summary_in,
   input  wire logic                  measurement_indicator_out,
   input  wire logic                  overcurrent_out_a,
   input  wire logic                  overcurrent_out_b
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic [3:0] reg_index(input logic [GPP_ADDR_W-1:0] addr);
      logic [GPP_ADDR_W-3:0] word;
      word = addr[GPP_ADDR_W-1:2];
      if (word <= (GPP_ADDR_W-2)'(GPP_IDX_LAST)) begin
         reg_index = word[3:0];
      end else begin
         reg_index = GPP_IDX_NONE;
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      merge = res & mask;
   endfunction

   // RQ13: setting 3h ticks once per 1024 clocks.
   function automatic logic tb_tick(input logic [GPP_PRE_W-1:0] pre, input logic [1:0] tb);
      logic [GPP_PRE_W-1:0] m;
      // RQ16: lower settings halve the base per step.
      m = GPP_PRE_W'((1 << (GPP_TB_LOG2_MIN + int'(tb))) - 1);
      tb_tick = ((pre & m) == m);
   endfunction

   // RQ17: quarters of the high-time share give codes 0 to 3.
   function automatic logic [1:0] duty_code(input logic [GPP_POS_W-1:0] lo,
                                            input logic [GPP_POS_W-1:0] hi);
      logic [10:0] sum;
      logic [10:0] h4;
      sum = 11'(lo) + 11'(hi);
      h4  = 11'(hi) << 2;
      if (h4 < sum) begin
         duty_code = GPP_CODE_Q0;
      end else if ((11'(hi) << 1) < sum) begin
         duty_code = GPP_CODE_Q1;
      end else if (h4 < 11'(sum * 11'h003)) begin
         duty_code = GPP_CODE_Q2;
      end else begin
         duty_code = GPP_CODE_Q3;
      end
   endfunction

   // ----------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------
   logic [GPP_ADDR_W-1:0]  aw_addr_r;
   logic [31:0]            w_data_r;
   logic [3:0]             w_strb_r;
   logic [31:0]            ctrl_r;
   logic [31:0]            src_r;
   logic [31:0]            tb_r;
   logic [31:0]            cnt_r [GPP_PINS];
   logic [GPP_PINS*2-1:0]  rdbk_r;
   logic [GPP_PRE_W-1:0]   pre_r;
   logic                   wr_go;
   logic [3:0]             wr_idx;
   logic [3:0]             rd_idx;
   logic [31:0]            rd_word;

   // Both halves held and no answer pending: the write lands exactly once.
   assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_idx = reg_index(aw_addr_r);
   assign rd_idx = reg_index(s_axi_araddr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= GPP_RESP_OKAY;
         aw_addr_r     <= '0;
         w_data_r      <= '0;
         w_strb_r      <= '0;
      end else begin
         if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_addr_r     <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx == GPP_IDX_NONE) ? GPP_RESP_SLVERR : GPP_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= GPP_RST_WORD;
         src_r  <= GPP_RST_WORD;
         tb_r   <= GPP_RST_WORD;
         for (int p = 0; p < GPP_PINS; p++) begin
            cnt_r[p] <= GPP_RST_WORD;
         end
      end else if (wr_go) begin
         case (wr_idx)
            GPP_IDX_CTRL: ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r, GPP_MASK_CTRL);
            GPP_IDX_SRC:  src_r  <= merge(src_r, w_data_r, w_strb_r, GPP_MASK_SRC);
            GPP_IDX_TB:   tb_r   <= merge(tb_r, w_data_r, w_strb_r, GPP_MASK_TB);
            default: begin
               for (int p = 0; p < GPP_PINS; p++) begin
                  if (wr_idx == GPP_IDX_CNT0 + 4'(p)) begin
                     cnt_r[p] <= merge(cnt_r[p], w_data_r, w_strb_r, GPP_MASK_CNT);
                  end
               end
            end
         endcase
      end
   end

   always_comb begin
      rd_word = '0;
      case (rd_idx)
         GPP_IDX_CTRL: rd_word = ctrl_r;
         GPP_IDX_SRC:  rd_word = src_r;
         GPP_IDX_TB:   rd_word = tb_r;
         GPP_IDX_RDBK: rd_word = 32'(rdbk_r);
         default: begin
            for (int p = 0; p < GPP_PINS; p++) begin
               if (rd_idx == GPP_IDX_CNT0 + 4'(p)) begin
                  rd_word = cnt_r[p];
               end
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= GPP_RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= (rd_idx == GPP_IDX_NONE) ? GPP_RESP_SLVERR : GPP_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Shared time-base prescaler
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Per-pin logic
   // ----------------------------------------------------------------
   for (genvar k = 0; k < GPP_PINS; k++) begin : g_pin
      gpp_pin_cfg_s          cfg;
      logic                  tick;
      logic                  special;
      logic                  sp_level;
      logic                  gen_on;
      logic                  per_end;
      logic                  pwm_level;
      logic [2:0]            sync_r;
      logic                  lvl_r;
      logic                  prev_r;
      logic                  run_r;
      logic [GPP_POS_W-1:0]  pos_r;
      logic [GPP_CNT_W-1:0]  cur_lc_r;
      logic [GPP_CNT_W-1:0]  cur_hc_r;
      logic [GPP_POS_W-1:0]  lo_r;
      logic [GPP_POS_W-1:0]  hi_r;
      logic [1:0]            code_r;

      assign cfg.dir   = ctrl_r[GPP_DIR_LSB + k];
      assign cfg.fmt   = ctrl_r[GPP_FMT_LSB + k];
      assign cfg.value = ctrl_r[GPP_VAL_LSB + k];
      assign cfg.src   = src_r[GPP_SRC_W*k +: GPP_SRC_W];
      assign cfg.tb    = tb_r[GPP_TB_W*k +: GPP_TB_W];
      assign cfg.ll_lc = cnt_r[k][GPP_LL_LC_LSB +: GPP_CNT_W];
      assign cfg.ll_hc = cnt_r[k][GPP_LL_HC_LSB +: GPP_CNT_W];
      assign cfg.lh_lc = cnt_r[k][GPP_LH_LC_LSB +: GPP_CNT_W];
      assign cfg.lh_hc = cnt_r[k][GPP_LH_HC_LSB +: GPP_CNT_W];

      assign tick = tb_tick(pre_r, cfg.tb);

      // RQ3: pick one of four status sources; pin 0 has none.
      always_comb begin
         special  = 1'b1;
         sp_level = 1'b0;
         case (gpp_src_e'(cfg.src))
            GPP_SRC_FAULT: sp_level = fault_summary_in;
            GPP_SRC_MEAS:  sp_level = measurement_indicator_out;
            GPP_SRC_OCA:   sp_level = overcurrent_out_a;
            GPP_SRC_OCB:   sp_level = overcurrent_out_b;
            default:       special  = 1'b0;
         endcase
      end

      assign gen_on    = cfg.dir && cfg.fmt && !special;
      assign per_end   = (9'(pos_r) + 9'h001) >= (9'(cur_lc_r) + 9'(cur_hc_r));
      // RQ11: the first ticks of each period form the low phase.
      assign pwm_level = pos_r >= GPP_POS_W'(cur_lc_r);

      // RQ12: start-up opens a period, so the first pair follows the data bit just written.
      always_ff @(posedge aclk) begin
         run_r <= aresetn && gen_on;
      end

      // RQ10: position counts time-base ticks through low then high phase.
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pos_r    <= '0;
            cur_lc_r <= '0;
            cur_hc_r <= '0;
         end else if (!gen_on || !run_r || (tick && per_end)) begin
            pos_r <= '0;
            // RQ9: data bit picks the counter pair; RQ12: only at period start.
            cur_lc_r <= cfg.value ? cfg.lh_lc : cfg.ll_lc;
            cur_hc_r <= cfg.value ? cfg.lh_hc : cfg.ll_hc;
         end else if (tick) begin
            pos_r <= pos_r + 1'b1;
         end
      end

      // RQ1: drive enable follows direction; RQ8: reset forces input.
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            gpio_oe[k]  <= 1'b0;
            gpio_out[k] <= 1'b0;
         end else begin
            gpio_oe[k] <= cfg.dir;
            // RQ6: special source masks the data bit.
            if (special) begin
               gpio_out[k] <= sp_level;
            // RQ2: format picks PWM or static drive.
            end else if (cfg.fmt) begin
               gpio_out[k] <= pwm_level;
            // RQ5: static push-pull level.
            end else begin
               gpio_out[k] <= cfg.value;
            end
         end
      end

      // The pin is asynchronous, so a level counts only once two later stages agree.
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            sync_r <= '0;
            lvl_r  <= 1'b0;
         end else begin
            sync_r <= {sync_r[1:0], gpio_in[k]};
            if (sync_r[1] == sync_r[2]) begin
               lvl_r <= sync_r[2];
            end
         end
      end

      // RQ14: measure low and high ticks, decode at each falling edge.
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            prev_r <= 1'b0;
            lo_r   <= '0;
            hi_r   <= '0;
            code_r <= GPP_CODE_Q0;
         end else begin
            prev_r <= lvl_r;
            if (prev_r && !lvl_r) begin
               // RQ15: a partial first period may misreport; the next is exact.
               code_r <= duty_code(lo_r, hi_r);
               lo_r   <= '0;
               hi_r   <= '0;
            end else if (tick) begin
               if (lvl_r) begin
                  if (hi_r != '1) begin
                     hi_r <= hi_r + 1'b1;
                  end else begin
                     code_r <= GPP_CODE_Q3;
                  end
               end else begin
                  if (lo_r != '1) begin
                     lo_r <= lo_r + 1'b1;
                  end else begin
                     code_r <= GPP_CODE_Q0;
                  end
               end
            end
         end
      end

      // RQ7: readback runs whatever the direction.
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            rdbk_r[GPP_RDBK_W*k +: GPP_RDBK_W] <= GPP_CODE_Q0;
         end else begin
            rdbk_r[GPP_RDBK_W*k +: GPP_RDBK_W] <= cfg.fmt ? code_r : {1'b0, lvl_r};
         end
      end
   end

endmodule
`default_nettype wire

/* verilog/gpp_pkg.sv */
// Constants, register map and carrier types for the five-pin PWM-capable GPIO port.
`default_nettype none
package gpp_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int GPP_PINS   = 5;
   localparam int GPP_ADDR_W = 8;
   localparam int GPP_CNT_W  = 7;
   localparam int GPP_POS_W  = 8;
   localparam int GPP_PRE_W  = 10;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [GPP_ADDR_W-1:0] GPP_ADDR_CTRL     = 8'h00;
   localparam logic [GPP_ADDR_W-1:0] GPP_ADDR_SRC      = 8'h04;
   localparam logic [GPP_ADDR_W-1:0] GPP_ADDR_TB       = 8'h08;
   localparam logic [GPP_ADDR_W-1:0] GPP_ADDR_RDBK     = 8'h0C;
   localparam logic [GPP_ADDR_W-1:0] GPP_ADDR_CNT_BASE = 8'h10;
   localparam logic [3:0]            GPP_IDX_CTRL      = 4'h0;
   localparam logic [3:0]            GPP_IDX_SRC       = 4'h1;
   localparam logic [3:0]            GPP_IDX_TB        = 4'h2;
   localparam logic [3:0]            GPP_IDX_RDBK      = 4'h3;
   localparam logic [3:0]            GPP_IDX_CNT0      = 4'h4;
   localparam logic [3:0]            GPP_IDX_LAST      = 4'h8;
   localparam logic [3:0]            GPP_IDX_NONE      = 4'hF;

   // ----------------------------------------------------------------
   // Field positions, write masks and reset values
   // ----------------------------------------------------------------
   localparam int GPP_DIR_LSB   = 0;
   localparam int GPP_FMT_LSB   = 8;
   localparam int GPP_VAL_LSB   = 16;
   localparam int GPP_SRC_W     = 3;
   localparam int GPP_TB_W      = 2;
   localparam int GPP_RDBK_W    = 2;
   localparam int GPP_LL_LC_LSB = 0;
   localparam int GPP_LL_HC_LSB = 8;
   localparam int GPP_LH_LC_LSB = 16;
   localparam int GPP_LH_HC_LSB = 24;
   localparam logic [31:0] GPP_MASK_CTRL = 32'h001F1F1F;
   localparam logic [31:0] GPP_MASK_SRC  = 32'h00007FF8;
   localparam logic [31:0] GPP_MASK_TB   = 32'h000003FF;
   localparam logic [31:0] GPP_MASK_CNT  = 32'h7F7F7F7F;
   localparam logic [31:0] GPP_RST_WORD  = 32'h00000000;

   // ----------------------------------------------------------------
   // Time base: setting n divides the main clock by 2**(GPP_TB_LOG2_MIN+n)
   // ----------------------------------------------------------------
   localparam int GPP_TB_LOG2_MIN = 7;

   // ----------------------------------------------------------------
   // Readback codes and bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0] GPP_CODE_Q0 = 2'h0;
   localparam logic [1:0] GPP_CODE_Q1 = 2'h1;
   localparam logic [1:0] GPP_CODE_Q2 = 2'h2;
   localparam logic [1:0] GPP_CODE_Q3 = 2'h3;
   localparam logic [1:0] GPP_RESP_OKAY   = 2'h0;
   localparam logic [1:0] GPP_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      GPP_SRC_NONE  = 3'h0,
      GPP_SRC_FAULT = 3'h1,
      GPP_SRC_MEAS  = 3'h2,
      GPP_SRC_OCA   = 3'h3,
      GPP_SRC_OCB   = 3'h4
   } gpp_src_e;

   typedef struct packed {
      logic                 dir;
      logic                 fmt;
      logic                 value;
      logic [2:0]           src;
      logic [1:0]           tb;
      logic [GPP_CNT_W-1:0] ll_lc;
      logic [GPP_CNT_W-1:0] ll_hc;
      logic [GPP_CNT_W-1:0] lh_lc;
      logic [GPP_CNT_W-1:0] lh_hc;
   } gpp_pin_cfg_s;

   typedef struct packed {
      logic                  valid;
      logic [GPP_ADDR_W-1:0] addr;
   } gpp_addr_s;
endpackage
`default_nettype wire
